// ===== bench/swt_line_rx.sv
`default_nettype none
module swt_line_rx (
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   line_pos,
    input  wire logic   line_neg,
    output logic        word_valid,
    output logic [31:0] word_bits,
    output int          data_len,
    output int          gap_len
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        act;
    logic        prev_act_ff;
    int          run_ff;
    int          nbits_ff;
    logic [31:0] sh_ff;
    // ------------------------------------------------------------
    // Bit slicer: a data bit starts when the line leaves null
    // ------------------------------------------------------------
    assign act = line_pos | line_neg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_valid  <= 1'b0;
            prev_act_ff <= 1'b0;
            run_ff      <= 0;
            nbits_ff    <= 0;
        end else begin
            word_valid  <= 1'b0;
            prev_act_ff <= act;
            if (act && !prev_act_ff) begin
                if (nbits_ff == 0) gap_len <= run_ff;
                sh_ff[nbits_ff] <= line_pos;
                nbits_ff        <= (nbits_ff == 31) ? 0 : nbits_ff + 1;
                word_valid      <= (nbits_ff == 31);
                word_bits       <= {line_pos, sh_ff[30:0]};
                run_ff          <= 1;
            end else if (act == prev_act_ff) begin
                run_ff <= run_ff + 1;
            end else begin
                data_len <= run_ff;
                run_ff   <= 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
module tb
    import swt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, par, wv;
    logic        tx_launch_enable, force_null, rpt_low_strobe, rpt_high_strobe;
    logic        line_out_pos, line_out_neg, slow_slope, tx_empty, loop_active, irq;
    logic        rx1_loop_pos, rx1_loop_neg, rx2_loop_pos, rx2_loop_neg;
    logic [7:0]  paddr;
    logic [15:0] rpt_data;
    logic [31:0] pwdata, prdata, rdv, wb, seed;
    int          dl, gl, got, error_cnt, cmp_count, act_ln, act_lb;
    logic [31:0] exp_q[$];

    swt_transmitter swt_transmitter_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .tx_launch_enable, .force_null, .rpt_low_strobe, .rpt_high_strobe,
        .rpt_data, .line_out_pos, .line_out_neg, .slow_slope, .tx_empty, .loop_active, .rx1_loop_pos,
        .rx1_loop_neg, .rx2_loop_pos, .rx2_loop_neg, .irq);
    swt_line_rx swt_line_rx_i (.pclk, .presetn, .line_pos(line_out_pos), .line_neg(line_out_neg),
        .word_valid(wv), .word_bits(wb), .data_len(dl), .gap_len(gl));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Split a word into {high half, low half} bus images
    function automatic logic [31:0] pack(input logic [30:0] w);
        logic [15:0] lo;
        lo = 16'h0000;
        for (int k = 0; k < 8; k++) lo[7-k] = w[k];
        for (int k = 0; k < 5; k++) lo[11+k] = w[8+k];
        lo[9]  = w[29];
        lo[10] = w[30];
        return {w[28:13], lo};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic load(input logic [30:0] w, input logic keep);
        logic [31:0] h;
        h = pack(w);
        apb(1'b1, OFS_TX_LOW_HALF, {16'h0000, h[15:0]});
        apb(1'b1, OFS_TX_HIGH_HALF, {16'h0000, h[31:16]});
        if (keep) exp_q.push_back({par ^ ~(^w), w});
    endtask

    task automatic rpt_load(input logic [30:0] w);
        logic [31:0] h;
        h = pack(w);
        rpt_data       <= h[15:0];
        rpt_low_strobe <= 1'b1;
        @(posedge pclk);
        rpt_low_strobe  <= 1'b0;
        rpt_data        <= h[31:16];
        rpt_high_strobe <= 1'b1;
        @(posedge pclk);
        rpt_high_strobe <= 1'b0;
        exp_q.push_back({par ^ ~(^w), w});
    endtask

    task automatic send(input int n);
        tx_launch_enable <= 1'b1;
        while (got < n) begin
            @(posedge pclk);
        end
        chk("empty", tx_empty, 1'b1);
        tx_launch_enable <= 1'b0;
        // Let the last word and its gap drain before any reconfiguration
        repeat (420) @(posedge pclk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        act_ln += int'(line_out_pos | line_out_neg);
        act_lb += int'(rx1_loop_pos | rx1_loop_neg);
        if (loop_active === 1'b1) chk("swap", {rx2_loop_pos, rx2_loop_neg}, {rx1_loop_neg, rx1_loop_pos});
        if (wv === 1'b1) begin
            got++;
            chk("word", wb, exp_q.size() > 0 ? exp_q.pop_front() : 32'hX);
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        seed = 32'h0000_6406;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_launch_enable, force_null, rpt_low_strobe, rpt_high_strobe, rpt_data} = '0;
        {par, got, error_cnt, cmp_count, act_ln, act_lb} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", rdv, CTRL_RESET);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", rdv & 32'h0000_00F1, 32'h0000_0001);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", {err, rdv[30:0]}, 32'h8000_0000);
        $display("test reset done");
        apb(1'b1, OFS_CTRL, 32'h0000_0021);
        for (int i = 0; i < 3; i++) load(31'(rnd()), 1'b1);
        rpt_load(31'(rnd()));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("count", rdv[7:0], 8'h40);
        send(4);
        chk("dlen", dl, 5);
        chk("gap", (gl >= 45 && gl <= 50), 1'b1);
        $display("test fast burst done");
        for (int i = 0; i < 9; i++) load(31'(rnd()), i < 8);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("full", rdv & 32'h0000_00F3, 32'h0000_0082);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk("drop", rdv[2], 1'b1);
        chk("irq off", irq, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
        @(posedge pclk);
        chk("irq on", irq, 1'b1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h0000_0004);
        @(posedge pclk);
        chk("irq clr", irq, 1'b0);
        send(12);
        $display("test full fifo done");
        apb(1'b1, OFS_CTRL, 32'h0000_3020);
        par = 1'b1;
        load(31'(rnd()), 1'b1);
        chk("slope", slow_slope, 1'b1);
        send(13);
        chk("dlen slow", dl, 40);
        $display("test slow even done");
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        par = 1'b0;
        load(31'(rnd()), 1'b1);
        chk("loop sel", loop_active, 1'b1);
        act_ln = 0;
        act_lb = 0;
        send(14);
        repeat (10) @(posedge pclk);
        chk("loop act", act_lb, act_ln);
        chk("line act", act_ln, 160);
        $display("test loopback done");
        load(31'(rnd()), 1'b0);
        tx_launch_enable <= 1'b1;
        repeat (100) @(posedge pclk);
        force_null <= 1'b1;
        repeat (2) @(posedge pclk);
        act_ln = 0;
        repeat (200) @(posedge pclk);
        chk("null", act_ln, 0);
        $display("test force null done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== design/swt_bit_divider.sv
`default_nettype none
module swt_bit_divider
    import swt_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow_sel,
    output logic      half_tick
);
    logic [5:0] cnt_ff;
    wire  [5:0] reload = slow_sel ? HALF_SLOW - 6'h01 : HALF_FAST - 6'h01;

    assign half_tick = (cnt_ff == 6'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 6'h00;
        end else if (half_tick) begin
            cnt_ff <= reload;
        end else begin
            cnt_ff <= cnt_ff - 6'h01;
        end
    end
endmodule
`default_nettype wire

// ===== design/swt_fifo.sv
`default_nettype none
module swt_fifo
    import swt_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              push_valid,
    output logic                   push_ready,
    input  wire logic [WORD_W-1:0] push_data,
    output logic                   pop_valid,
    input  wire logic              pop_ready,
    output logic [WORD_W-1:0]      pop_data,
    output logic [CNT_W-1:0]       count
);
    logic [WORD_W-1:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0]  wr_ptr_ff;
    logic [PTR_W-1:0]  rd_ptr_ff;
    logic [CNT_W-1:0]  cnt_ff;
    wire               do_push = push_valid & push_ready;
    wire               do_pop  = pop_valid & pop_ready;

    assign push_ready = (cnt_ff != CNT_W'(FIFO_DEPTH));
    assign pop_valid  = (cnt_ff != '0);
    assign pop_data   = mem[rd_ptr_ff];
    assign count      = cnt_ff;

    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + PTR_W'(do_push);
            rd_ptr_ff <= rd_ptr_ff + PTR_W'(do_pop);
            cnt_ff    <= cnt_ff + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end
endmodule
`default_nettype wire

// ===== design/swt_transmitter.sv
// Operation
// RULE1: Host loads low half, then high half
// RULE2: FIFO holds eight words, ignores loads when full
// RULE3: Empty flag high exactly when FIFO empty
// RULE4: Launch pops oldest word, first bit soon
// RULE5: Fast rate: 5 data, 5 null, 40 gap
// RULE6: Slow rate: 40 data, 40 null, 320 gap
// RULE7: Word counter raises empty flag when drained
// RULE8: Parity bit 32, odd or even by control
// RULE9: Loopback feeds transmitter states to receivers
// RULE10: Receiver one true, receiver two complemented
// RULE11: Loopback words still appear on line
// RULE12: Force-null input holds both outputs null
// RULE13: Host keeps launch enable until empty flag
// RULE14: One positive, zero negative, null zero
// RULE15: Rate bit also selects output slope
// RULE16: Repeater loads received halves, low first
// RULE17: Bit clock is master divided 10 or 80
// RULE18: Serial bit one goes first, ascending
// RULE19: Outputs rest null when not sending
`default_nettype none
module swt_transmitter
    import swt_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              tx_launch_enable,
    input  wire logic              force_null,
    input  wire logic              rpt_low_strobe,
    input  wire logic              rpt_high_strobe,
    input  wire logic [15:0]       rpt_data,
    output logic                   line_out_pos,
    output logic                   line_out_neg,
    output logic                   slow_slope,
    output logic                   tx_empty,
    output logic                   loop_active,
    output logic                   rx1_loop_pos,
    output logic                   rx1_loop_neg,
    output logic                   rx2_loop_pos,
    output logic                   rx2_loop_neg,
    output logic                   irq
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0]      ctrl_ff;
    logic [31:0]      prdata_ff;
    logic [15:0]      low_half_ff;
    logic             low_valid_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_mask_ff;

    wire setup    = psel & ~penable;
    wire access   = psel & penable;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_lo   = (paddr == OFS_TX_LOW_HALF);
    wire hit_hi   = (paddr == OFS_TX_HIGH_HALF);
    wire hit_stat = (paddr == OFS_STATUS);
    wire hit_ist  = (paddr == OFS_IRQ_STATUS);
    wire hit_imsk = (paddr == OFS_IRQ_MASK);
    wire addr_hit = hit_ctrl | hit_lo | hit_hi | hit_stat | hit_ist | hit_imsk;
    wire wr_en    = access & pwrite;

    wire parity_sense_bit    = ctrl_ff[CTRL_PARITY_POS];
    wire loopback_select_bit = ctrl_ff[CTRL_LOOPBACK_POS];
    wire rate_select_bit     = ctrl_ff[CTRL_RATE_POS];
    wire repeat_enable       = ctrl_ff[CTRL_REPEAT_POS];

    assign pready  = 1'b1;
    assign pslverr = access & ~addr_hit;
    assign prdata  = prdata_ff;

    // ------------------------------------------------------------
    // Half-word assembly
    // ------------------------------------------------------------
    wire apb_low  = wr_en & hit_lo;
    wire apb_high = wr_en & hit_hi;
    wire rpt_low  = repeat_enable & rpt_low_strobe;
    wire rpt_high = repeat_enable & rpt_high_strobe;

    wire        load_low_half_strobe  = apb_low | rpt_low;                        // RULE16
    wire        load_high_half_strobe = apb_high | rpt_high;                      // RULE16
    wire [15:0] low_in                = apb_low ? pwdata[15:0] : rpt_data;
    wire [15:0] high_in               = apb_high ? pwdata[15:0] : rpt_data;

    // Word bit i is serial bit i+1; bus bit 8 carries no data on load
    wire [WORD_W-1:0] word_in = {low_half_ff[10], low_half_ff[9], high_in, low_half_ff[15:11],
                                 low_half_ff[0], low_half_ff[1], low_half_ff[2], low_half_ff[3],
                                 low_half_ff[4], low_half_ff[5], low_half_ff[6], low_half_ff[7]};

    // High half only completes a word after a fresh low half
    wire push_req = load_high_half_strobe & low_valid_ff;                         // RULE1

    // ------------------------------------------------------------
    // Word store and bit clock
    // ------------------------------------------------------------
    logic              push_ready;
    logic              pop_valid;
    logic              pop_ready;
    logic [WORD_W-1:0] head_word;
    logic [CNT_W-1:0]  word_count;
    logic              half_tick;

    swt_fifo u_fifo (
        .pclk       (pclk),
        .presetn    (presetn),
        .push_valid (push_req),
        .push_ready (push_ready),
        .push_data  (word_in),
        .pop_valid  (pop_valid),
        .pop_ready  (pop_ready),
        .pop_data   (head_word),
        .count      (word_count)
    );

    swt_bit_divider u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .slow_sel  (rate_select_bit),                                                 // RULE17
        .half_tick (half_tick)
    );

    wire load_drop = push_req & ~push_ready;                                      // RULE2
    assign tx_empty = ~pop_valid;                                                 // RULE3 RULE7

    // ------------------------------------------------------------
    // Serial sequencer
    // ------------------------------------------------------------
    swt_state_e st_ff;
    swt_state_e nxt_st;
    logic [31:0] shift_ff;
    logic [4:0]  bit_cnt_ff;
    logic [2:0]  gap_cnt_ff;

    wire go        = tx_launch_enable & pop_valid;
    wire gap_done  = (st_ff == ST_GAP) & half_tick & (gap_cnt_ff == GAP_LAST);
    wire last_bit  = (bit_cnt_ff == BIT_LAST);
    wire word_sent = (st_ff == ST_NULL) & half_tick & last_bit;
    assign pop_ready = go & ((st_ff == ST_IDLE) | gap_done);                      // RULE4

    // Ones in word plus parity: odd when sense low, even when high
    wire parity_bit = ~(^head_word) ^ parity_sense_bit;                           // RULE8

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: begin
                if (go) begin
                    nxt_st = ST_LOAD;                                             // RULE4
                end
            end
            ST_LOAD: begin
                if (half_tick) begin
                    nxt_st = ST_DATA;
                end
            end
            ST_DATA: begin
                if (half_tick) begin
                    nxt_st = ST_NULL;                                             // RULE5 RULE6
                end
            end
            ST_NULL: begin
                if (half_tick) begin
                    nxt_st = last_bit ? ST_GAP : ST_DATA;
                end
            end
            ST_GAP: begin
                if (gap_done) begin
                    nxt_st = go ? ST_DATA : ST_IDLE;                              // RULE5 RULE6
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ff   <= 32'h0000_0000;
            bit_cnt_ff <= 5'h00;
        end else if (pop_ready) begin
            shift_ff   <= {parity_bit, head_word};
            bit_cnt_ff <= 5'h00;
        end else if ((st_ff == ST_NULL) & half_tick & ~last_bit) begin
            shift_ff   <= {1'b0, shift_ff[31:1]};                                 // RULE18
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_ff <= 3'h0;
        end else if (st_ff != ST_GAP) begin
            gap_cnt_ff <= 3'h0;
        end else if (half_tick) begin
            gap_cnt_ff <= gap_cnt_ff + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Line driver and loopback
    // ------------------------------------------------------------
    logic pos_ff;
    logic neg_ff;
    logic lb_pos_ff;
    logic lb_neg_ff;
    logic lb_act_ff;

    wire in_data = (st_ff == ST_DATA);
    wire bit_one = in_data & shift_ff[0];                                         // RULE14
    wire bit_zer = in_data & ~shift_ff[0];                                        // RULE14
    wire lb_on   = ~loopback_select_bit;                                          // RULE9

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff    <= 1'b0;
            neg_ff    <= 1'b0;
            lb_pos_ff <= 1'b0;
            lb_neg_ff <= 1'b0;
            lb_act_ff <= 1'b0;
        end else begin
            pos_ff    <= bit_one & ~force_null;                                   // RULE11 RULE12 RULE19
            neg_ff    <= bit_zer & ~force_null;                                   // RULE11 RULE12 RULE19
            lb_pos_ff <= bit_one & lb_on;                                         // RULE9
            lb_neg_ff <= bit_zer & lb_on;                                         // RULE9
            lb_act_ff <= lb_on;
        end
    end

    assign line_out_pos = pos_ff;
    assign line_out_neg = neg_ff;
    assign loop_active  = lb_act_ff;
    assign rx1_loop_pos = lb_pos_ff;
    assign rx1_loop_neg = lb_neg_ff;
    assign rx2_loop_pos = lb_neg_ff;                                              // RULE10
    assign rx2_loop_neg = lb_pos_ff;                                              // RULE10
    assign slow_slope   = rate_select_bit;                                        // RULE15

    // ------------------------------------------------------------
    // Registers and interrupts
    // ------------------------------------------------------------
    logic tx_empty_d_ff;
    wire  [IRQ_W-1:0] irq_ev  = {load_drop, word_sent, tx_empty & ~tx_empty_d_ff};
    wire  [IRQ_W-1:0] irq_clr = (wr_en & hit_ist) ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
    wire  [31:0]      status_rd = {23'h0, low_valid_ff, word_count, 1'b0,
                                   (st_ff != ST_IDLE), ~push_ready, tx_empty};
    wire  [31:0]      rd_mux =
        hit_ctrl ? ctrl_ff :
        hit_lo   ? {16'h0000, low_half_ff} :
        hit_stat ? status_rd :
        hit_ist  ? {29'h0, irq_stat_ff} :
        hit_imsk ? {29'h0, irq_mask_ff} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff       <= CTRL_RESET;
            irq_mask_ff   <= IRQ_MASK_RESET;
            irq_stat_ff   <= '0;
            tx_empty_d_ff <= 1'b1;
            prdata_ff     <= 32'h0000_0000;
        end else begin
            if (wr_en & hit_ctrl) begin
                ctrl_ff <= pwdata & CTRL_WR_MASK;
            end
            if (wr_en & hit_imsk) begin
                irq_mask_ff <= pwdata[IRQ_W-1:0];
            end
            irq_stat_ff   <= (irq_stat_ff & ~irq_clr) | irq_ev;
            tx_empty_d_ff <= tx_empty;
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_half_ff  <= 16'h0000;
            low_valid_ff <= 1'b0;
        end else if (load_low_half_strobe) begin
            low_half_ff  <= low_in;                                               // RULE1
            low_valid_ff <= 1'b1;
        end else if (load_high_half_strobe) begin
            low_valid_ff <= 1'b0;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_full_ignore: assert property (@(posedge pclk) disable iff (!presetn)   // RULE2
        (push_req && !push_ready && !pop_ready) |=> (word_count == CNT_W'(FIFO_DEPTH)))
        else $error("load accepted while full");

    a_empty_flag: assert property (@(posedge pclk) disable iff (!presetn)    // RULE7
        (pop_ready && word_count == 4'h1 && !push_req) |=> tx_empty)
        else $error("empty flag not raised after last word");

    a_launch_time: assert property (@(posedge pclk) disable iff (!presetn)   // RULE4
        (st_ff == ST_IDLE && go) |-> ##[1:45] (st_ff == ST_DATA))
        else $error("first bit late after launch");

    a_fast_half: assert property (@(posedge pclk) disable iff (!presetn)     // RULE5
        ($rose(st_ff == ST_DATA) && !rate_select_bit) |-> (st_ff == ST_DATA)[*5] ##1 (st_ff == ST_NULL))
        else $error("fast data half not five clocks");

    a_fast_gap: assert property (@(posedge pclk) disable iff (!presetn)      // RULE5
        ($rose(st_ff == ST_GAP) && !rate_select_bit) |-> ##39 (st_ff == ST_GAP) ##1 (st_ff != ST_GAP))
        else $error("fast word gap not forty clocks");

    a_parity_odd: assert property (@(posedge pclk) disable iff (!presetn)    // RULE8
        $rose(st_ff == ST_LOAD) |-> ((^shift_ff) == !parity_sense_bit))
        else $error("parity bit wrong");

    a_force_null: assert property (@(posedge pclk) disable iff (!presetn)    // RULE12
        force_null |=> (!line_out_pos && !line_out_neg))
        else $error("line not null under force");

    a_null_rest: assert property (@(posedge pclk) disable iff (!presetn)     // RULE19
        (st_ff != ST_DATA) |=> (!line_out_pos && !line_out_neg))
        else $error("line not null outside data");

    a_line_code: assert property (@(posedge pclk) disable iff (!presetn)     // RULE14
        (in_data && !force_null) |=> (line_out_pos == $past(shift_ff[0]) && line_out_neg != line_out_pos))
        else $error("line level does not match bit");

    a_loop_compl: assert property (@(posedge pclk) disable iff (!presetn)    // RULE10
        (lb_on && !force_null) |=> ({rx1_loop_pos, rx2_loop_pos} == {line_out_pos, line_out_neg}))
        else $error("receiver two not complement");
endmodule
`default_nettype wire

// ===== pkg/swt_pkg.sv
`default_nettype none
package swt_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int           ADDR_W           = 8;
    localparam logic [7:0]   OFS_CTRL         = 8'h00;
    localparam logic [7:0]   OFS_TX_LOW_HALF  = 8'h04;
    localparam logic [7:0]   OFS_TX_HIGH_HALF = 8'h08;
    localparam logic [7:0]   OFS_STATUS       = 8'h0C;
    localparam logic [7:0]   OFS_IRQ_STATUS   = 8'h10;
    localparam logic [7:0]   OFS_IRQ_MASK     = 8'h14;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int           CTRL_REPEAT_POS   = 0;
    localparam int           CTRL_LOOPBACK_POS = 5;
    localparam int           CTRL_PARITY_POS   = 12;
    localparam int           CTRL_RATE_POS     = 13;
    localparam logic [31:0]  CTRL_RESET        = 32'h0000_0020;
    localparam logic [31:0]  CTRL_WR_MASK      = 32'h0000_3021;

    // ------------------------------------------------------------
    // Interrupt fields
    // ------------------------------------------------------------
    localparam int           IRQ_W          = 3;
    localparam int           IRQ_EMPTY_POS  = 0;
    localparam int           IRQ_SENT_POS   = 1;
    localparam int           IRQ_DROP_POS   = 2;
    localparam logic [2:0]   IRQ_MASK_RESET = 3'h0;

    // ------------------------------------------------------------
    // Word store
    // ------------------------------------------------------------
    localparam int           WORD_W     = 31;
    localparam int           FIFO_DEPTH = 8;
    localparam int           PTR_W      = 3;
    localparam int           CNT_W      = 4;

    // ------------------------------------------------------------
    // Timing, in master clocks
    // ------------------------------------------------------------
    localparam int           BIT_CLK_FAST = 10;
    localparam int           BIT_CLK_SLOW = 80;
    localparam int           GAP_CLK_FAST = 40;
    localparam logic [5:0]   HALF_FAST    = 6'(BIT_CLK_FAST / 2);
    localparam logic [5:0]   HALF_SLOW    = 6'(BIT_CLK_SLOW / 2);
    localparam int           GAP_HALVES   = GAP_CLK_FAST / (BIT_CLK_FAST / 2);
    localparam logic [2:0]   GAP_LAST     = 3'(GAP_HALVES - 1);
    localparam logic [4:0]   BIT_LAST     = 5'h1F;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LOAD = 5'b00010,
        ST_DATA = 5'b00100,
        ST_NULL = 5'b01000,
        ST_GAP  = 5'b10000
    } swt_state_e;

endpackage
`default_nettype wire
